// ==== rtl/ctp_consts.svh ====
// constants for the cascaded 16-bit timer with pwm output
// assumes a single 250 MHz system clock and a word-aligned register bus
// Functional notes
// - two halves form one 16-bit up-counter
// - match raises interrupt, clears, keeps counting
// - compare unbuffered outside pwm, instantly effective
// - event mode counts count pin falling edges
// - pwm width match toggles flop, no clear
// - pwm overflow toggles flop, clears, interrupts
// - preset bit loads flop; reset clears it
// - pwm pin shows inverted flop state
// - width double buffered, loads at interrupt
// - width read returns active value in pwm
// - stop holds pin; preset only after stop
// - selectable prescaled fc and fs source clocks
`ifndef CTP_CONSTS_SVH
`define CTP_CONSTS_SVH

// register byte offsets
`define CTP_OFS_LOWER_CTRL   5'h00
`define CTP_OFS_UPPER_CTRL   5'h04
`define CTP_OFS_CMP_LO       5'h08
`define CTP_OFS_CMP_HI       5'h0c
`define CTP_OFS_WID_LO       5'h10
`define CTP_OFS_WID_HI       5'h14
`define CTP_OFS_STATUS       5'h18
`define CTP_OFS_COUNT        5'h1c

// lower half control fields
`define CTP_LC_SRC_LSB       0
`define CTP_LC_SRC_MSB       2
`define CTP_LC_DIVSEL        3
`define CTP_LC_SLOW          4
`define CTP_LC_HPRESET       5

// upper half control fields
`define CTP_UC_MODE_LSB      0
`define CTP_UC_MODE_MSB      1
`define CTP_UC_RUN           2
`define CTP_UC_PRESET        3

// status fields
`define CTP_ST_FLOP          0
`define CTP_ST_RUN           1

// source clock select codes
`define CTP_SRC_FC_D11       3'h0
`define CTP_SRC_FC_D7        3'h1
`define CTP_SRC_FC_D5        3'h2
`define CTP_SRC_FC_D3        3'h3
`define CTP_SRC_FS           3'h4
`define CTP_SRC_FC_D1        3'h5
`define CTP_SRC_FC           3'h6
`define CTP_SRC_EXT          3'h7

// prescaler taps, msb index of the all-ones test
`define CTP_PRE_W            11
`define CTP_TAP_D11          10
`define CTP_TAP_D7           6
`define CTP_TAP_D5           4
`define CTP_TAP_D3           2
`define CTP_TAP_D1           0
`define CTP_FS_DIV_W         3

// reset values, count limits and the increment step
`define CTP_RST_BYTE         8'h00
`define CTP_RST_HALF         8'h00
`define CTP_RST_WORD         16'h0000
`define CTP_HALF_MAX         8'hff
`define CTP_WORD_MAX         16'hffff
`define CTP_ONE_BYTE         8'h01

`endif

// ==== rtl/ctp_pkg.sv ====
// types shared by the cascaded timer
// assumes the constants header is included by the design file
package ctp_pkg;
  // operating modes of the cascaded counter
  typedef enum logic [1:0] {
    CTP_TIMER,
    CTP_EVENT,
    CTP_PWM,
    CTP_RSVD
  } ctp_mode_e;
endpackage

// ==== rtl/ctp_timer.sv ====
// cascaded 16-bit timer, event counter and pwm generator with avalon slave
// assumes async pins count_input_pin_i and fs_clk_i, synced here
`timescale 1ns/1ps
`include "ctp_consts.svh"

module ctp_timer (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [4:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  input  wire logic [3:0]  byteenable_i,
  output logic      [31:0] readdata_o,
  output logic             waitrequest_o,
  input  wire logic        count_input_pin_i,
  input  wire logic        fs_clk_i,
  output logic             pwm_out_pin_o,
  output logic             cascade_interrupt_o
);

  // register state
  logic [2:0]  src_sel;
  logic        divider_select_bit;
  logic        slow_mode;
  logic        half_flop_preset_bit;
  logic [1:0]  mode_field;
  logic        run_bit;
  logic        flop_preset_bit;
  logic [7:0]  compare_low_byte;
  logic [7:0]  compare_high_byte;
  logic [7:0]  width_low_byte;
  logic [7:0]  width_high_byte;
  logic [15:0] width_active;
  logic [7:0]  lower_half;
  logic [7:0]  upper_half;
  logic        output_flipflop;
  logic        ack;

  // synchronisers and clock dividers
  logic        cnt_pin_s1;
  logic        cnt_pin_s2;
  logic        cnt_pin_prev;
  logic        fs_s1;
  logic        fs_s2;
  logic        fs_prev;
  logic [`CTP_PRE_W-1:0]    pre_cnt;
  logic [`CTP_FS_DIV_W-1:0] fs_div;

  // bus handshake: one wait cycle, then the access completes
  wire         req      = read_i | write_i;
  wire         acc_wr   = write_i & ack;
  wire         be_lo    = byteenable_i[0];
  assign waitrequest_o  = req & ~ack;

  // write strobes
  wire wr_lower  = acc_wr & be_lo & (address_i == `CTP_OFS_LOWER_CTRL);
  wire wr_upper  = acc_wr & be_lo & (address_i == `CTP_OFS_UPPER_CTRL);
  wire wr_cmp_lo = acc_wr & be_lo & (address_i == `CTP_OFS_CMP_LO);
  wire wr_cmp_hi = acc_wr & be_lo & (address_i == `CTP_OFS_CMP_HI);
  wire wr_wid_lo = acc_wr & be_lo & (address_i == `CTP_OFS_WID_LO);
  wire wr_wid_hi = acc_wr & be_lo & (address_i == `CTP_OFS_WID_HI);
  wire new_run   = writedata_i[`CTP_UC_RUN];

  // mode decode
  ctp_pkg::ctp_mode_e mode;
  assign mode = ctp_pkg::ctp_mode_e'(mode_field);
  wire is_pwm   = (mode == ctp_pkg::CTP_PWM);
  wire is_event = (mode == ctp_pkg::CTP_EVENT);

  // counter and register views
  wire [15:0] count_val   = {upper_half, lower_half};
  wire [15:0] compare_val = {compare_high_byte, compare_low_byte};
  wire [15:0] width_buf   = {width_high_byte, width_low_byte};
  wire [15:0] width_view  = is_pwm ? width_active : width_buf;

  // source ticks from the free prescaler, the slow clock and the count pin
  wire fs_tick   = fs_s2 & ~fs_prev;
  wire fs8_tick  = fs_tick & (&fs_div);
  wire ext_tick  = cnt_pin_prev & ~cnt_pin_s2;
  wire t_d11     = &pre_cnt[`CTP_TAP_D11:0];
  wire t_d7      = &pre_cnt[`CTP_TAP_D7:0];
  wire t_d5      = &pre_cnt[`CTP_TAP_D5:0];
  wire t_d3      = &pre_cnt[`CTP_TAP_D3:0];
  wire t_d1      = pre_cnt[`CTP_TAP_D1];
  wire first_src = divider_select_bit ? fs8_tick : t_d11;

  // selected internal source, fc taps blocked in slow mode
  logic int_tick;
  always_comb begin
    int_tick = 1'b0;
    unique case (src_sel)
      `CTP_SRC_FC_D11: int_tick = slow_mode ? fs8_tick : first_src;
      `CTP_SRC_FC_D7:  int_tick = ~slow_mode & t_d7;
      `CTP_SRC_FC_D5:  int_tick = ~slow_mode & t_d5;
      `CTP_SRC_FC_D3:  int_tick = ~slow_mode & t_d3;
      `CTP_SRC_FS:     int_tick = fs_tick;
      `CTP_SRC_FC_D1:  int_tick = ~slow_mode & t_d1;
      `CTP_SRC_FC:     int_tick = ~slow_mode;
      `CTP_SRC_EXT:    int_tick = ext_tick;
    endcase
  end

  // count enable per mode; reserved mode never counts
  logic tick;
  always_comb begin
    tick = 1'b0;
    unique case (mode)
      ctp_pkg::CTP_TIMER: tick = (src_sel != `CTP_SRC_EXT) & int_tick;
      ctp_pkg::CTP_EVENT: tick = ext_tick;
      ctp_pkg::CTP_PWM:   tick = int_tick;
      default:            tick = 1'b0;
    endcase
  end

  // match, overflow and clear decode
  wire step      = run_bit & tick;
  wire cmp_match = ~is_pwm & (count_val == compare_val);
  wire wid_match = is_pwm & (count_val == width_active);
  wire overflow  = is_pwm & (count_val == `CTP_WORD_MAX);
  wire clr_evt   = cmp_match | overflow;
  wire carry     = (lower_half == `CTP_HALF_MAX);
  wire start_wr  = wr_upper & ~run_bit & new_run;
  wire flop_load = wr_upper & ~run_bit;

  // read data mux
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (address_i)
      `CTP_OFS_LOWER_CTRL: begin
        rd_mux[`CTP_LC_SRC_MSB:`CTP_LC_SRC_LSB] = src_sel;
        rd_mux[`CTP_LC_DIVSEL]  = divider_select_bit;
        rd_mux[`CTP_LC_SLOW]    = slow_mode;
        rd_mux[`CTP_LC_HPRESET] = half_flop_preset_bit;
      end
      `CTP_OFS_UPPER_CTRL: begin
        rd_mux[`CTP_UC_MODE_MSB:`CTP_UC_MODE_LSB] = mode_field;
        rd_mux[`CTP_UC_RUN]    = run_bit;
        rd_mux[`CTP_UC_PRESET] = flop_preset_bit;
      end
      `CTP_OFS_CMP_LO: rd_mux[7:0] = compare_low_byte;
      `CTP_OFS_CMP_HI: rd_mux[7:0] = compare_high_byte;
      `CTP_OFS_WID_LO: rd_mux[7:0] = width_view[7:0];
      `CTP_OFS_WID_HI: rd_mux[7:0] = width_view[15:8];
      `CTP_OFS_STATUS: begin
        rd_mux[`CTP_ST_FLOP] = output_flipflop;
        rd_mux[`CTP_ST_RUN]  = run_bit;
      end
      `CTP_OFS_COUNT:  rd_mux[15:0] = count_val;
      default:         rd_mux = 32'h0000_0000;                  // unmapped
    endcase
  end

  // bus answer: read data captured in the wait cycle
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ack        <= 1'b0;
      readdata_o <= 32'h0000_0000;
    end else begin
      ack <= req & ~ack;
      if (read_i & ~ack)
        readdata_o <= rd_mux;
    end
  end

  // two-flop synchronisers and edge history for the async pins
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      cnt_pin_s1   <= 1'b1;
      cnt_pin_s2   <= 1'b1;
      cnt_pin_prev <= 1'b1;
      fs_s1        <= 1'b0;
      fs_s2        <= 1'b0;
      fs_prev      <= 1'b0;
    end else begin
      cnt_pin_s1   <= count_input_pin_i;
      cnt_pin_s2   <= cnt_pin_s1;
      cnt_pin_prev <= cnt_pin_s2;
      fs_s1        <= fs_clk_i;
      fs_s2        <= fs_s1;
      fs_prev      <= fs_s2;
    end
  end

  // free-running fc prescaler and fs divide-by-eight
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pre_cnt <= '0;
      fs_div  <= '0;
    end else begin
      pre_cnt <= pre_cnt + 1'b1;
      if (fs_tick)
        fs_div <= fs_div + 1'b1;
    end
  end

  // lower half control register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      src_sel              <= `CTP_SRC_FC_D11;
      divider_select_bit   <= 1'b0;
      slow_mode            <= 1'b0;
      half_flop_preset_bit <= 1'b0;
    end else if (wr_lower) begin
      src_sel              <= writedata_i[`CTP_LC_SRC_MSB:`CTP_LC_SRC_LSB];
      divider_select_bit   <= writedata_i[`CTP_LC_DIVSEL];
      slow_mode            <= writedata_i[`CTP_LC_SLOW];
      half_flop_preset_bit <= writedata_i[`CTP_LC_HPRESET];
    end
  end

  // upper half control register; every write loads mode, run and preset
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mode_field      <= 2'h0;
      run_bit         <= 1'b0;
      flop_preset_bit <= 1'b0;
    end else if (wr_upper) begin
      mode_field <= writedata_i[`CTP_UC_MODE_MSB:`CTP_UC_MODE_LSB];
      run_bit    <= new_run;
      flop_preset_bit <= writedata_i[`CTP_UC_PRESET];
    end
  end

  // compare bytes, used directly by the comparator
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      compare_low_byte  <= `CTP_RST_BYTE;
      compare_high_byte <= `CTP_RST_BYTE;
    end else begin
      if (wr_cmp_lo)
        compare_low_byte <= writedata_i[7:0];
      if (wr_cmp_hi)
        compare_high_byte <= writedata_i[7:0];
    end
  end

  // width write buffer
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      width_low_byte  <= `CTP_RST_BYTE;
      width_high_byte <= `CTP_RST_BYTE;
    end else begin
      if (wr_wid_lo)
        width_low_byte <= writedata_i[7:0];
      if (wr_wid_hi)
        width_high_byte <= writedata_i[7:0];
    end
  end

  // active width: follows buffer when stopped or outside pwm, loads at interrupt when run in pwm
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      width_active <= `CTP_RST_WORD;
    else if (!run_bit || !is_pwm)
      width_active <= width_buf;
    else if (step && overflow)
      width_active <= width_buf;
  end

  // cascaded counter halves with carry from lower to upper
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      lower_half <= `CTP_RST_HALF;
      upper_half <= `CTP_RST_HALF;
    end else if (start_wr) begin
      lower_half <= `CTP_RST_HALF;
      upper_half <= `CTP_RST_HALF;
    end else if (step) begin
      if (clr_evt) begin
        lower_half <= `CTP_RST_HALF;
        upper_half <= `CTP_RST_HALF;
      end else begin
        lower_half <= lower_half + `CTP_ONE_BYTE;
        if (carry)
          upper_half <= upper_half + `CTP_ONE_BYTE;
      end
    end
  end

  // output flip-flop: preset while stopped, toggles in pwm
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      output_flipflop <= 1'b0;
    else if (flop_load)
      output_flipflop <= writedata_i[`CTP_UC_PRESET];
    else if (step && is_pwm)
      output_flipflop <= output_flipflop ^ wid_match ^ overflow;
  end

  // cascade interrupt pulse, one cycle per match or overflow
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i)
      cascade_interrupt_o <= 1'b0;
    else
      cascade_interrupt_o <= step & clr_evt;
  end

  // pin shows the inverse; stopped counter leaves it unchanged
  assign pwm_out_pin_o = ~output_flipflop;

endmodule

// ==== testbench/ctp_far_side.sv ====
// far side model: event pulses on the count pin and a slow fs clock
// assumes the bench pulses start_i for one cycle with pulses_i set
`timescale 1ns/1ps

module ctp_far_side (
  input  wire logic       clk_sys_i,
  input  wire logic       start_i,
  input  wire logic [7:0] pulses_i,
  output logic            count_pin_o,
  output logic            fs_clk_o,
  output logic            busy_o
);
  int n;
  // pin idles high as with a pull-up
  initial begin
    count_pin_o = 1'b1;
    fs_clk_o = 1'b0;
    busy_o = 1'b0;
  end
  // fs clock runs free, 40 system cycles a period
  always begin
    repeat (20) @(posedge clk_sys_i);
    fs_clk_o <= ~fs_clk_o;
  end
  // each phase held three cycles, above the two-cycle minimum
  always @(posedge clk_sys_i) begin
    if (start_i) begin
      busy_o <= 1'b1;
      for (n = 0; n < pulses_i; n++) begin
        count_pin_o <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        count_pin_o <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
      end
      busy_o <= 1'b0;
    end
  end
endmodule

// ==== testbench/ctp_monitor.sv ====
// port checker for the cascaded timer
// assumes it is bound to ctp_timer and sees only its ports
`timescale 1ns/1ps
`include "ctp_consts.svh"

module ctp_monitor (
  input wire logic        clk_sys_i,
  input wire logic        resetn_i,
  input wire logic [4:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        pwm_out_pin_o,
  input wire logic        cascade_interrupt_o
);
  // request and completed read
  wire logic req     = read_i | write_i;
  wire logic rd_done = read_i & ~waitrequest_o;
  wire logic st_rd   = rd_done & (address_i == `CTP_OFS_STATUS);

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);

  chk_wait_first: assert property (req && !$past(req) |-> waitrequest_o)
    else $error("waitrequest low in first request cycle");
  chk_wait_one: assert property (req && waitrequest_o |=> !waitrequest_o)
    else $error("more than one wait cycle");
  chk_wait_idle: assert property (!req |-> !waitrequest_o)
    else $error("waitrequest high with no request");
  chk_data_hold: assert property (!read_i |=> $stable(readdata_o))
    else $error("read data moved without a read");
  chk_unmapped_zero: assert property (
    rd_done && address_i[1:0] != 2'h0 |-> readdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_status_pin: assert property (
    st_rd |-> readdata_o[0] == !pwm_out_pin_o)
    else $error("pin is not inverse of flop");
  chk_status_high: assert property (st_rd |-> readdata_o[31:2] == 30'h0)
    else $error("status spare bits not zero");
  chk_ctrl_spare: assert property (rd_done &&
    address_i == `CTP_OFS_UPPER_CTRL |-> readdata_o[31:4] == 28'h0)
    else $error("control spare bits not zero");
  chk_pin_reset: assert property ($rose(resetn_i) |->
    pwm_out_pin_o && !cascade_interrupt_o)
    else $error("flop or interrupt not cleared by reset");
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench: bus, source clocks, event count and pwm
// assumes ctp_timer, ctp_far_side and ctp_monitor are compiled first
`timescale 1ns/1ps
`include "ctp_consts.svh"

module testbench;
  logic        clk_sys_i, resetn_i, read_i, write_i, go;
  logic [4:0]  address_i;
  logic [31:0] writedata_i;
  logic [3:0]  byteenable_i;
  logic [7:0]  npulse, rnd;
  logic [31:0] exp_q [$];
  logic [7:0]  lc [11];
  logic [15:0] cm [11];
  int          per [11];
  int          err_total, n_compared, g, i;
  wire logic   count_pin, fs_clk, busy, pin, irq, waitreq;
  wire logic [31:0] readdata;

  // pin is watched directly, as though its port latch were held at 1
  ctp_timer u_ctp_timer (.clk_sys_i, .resetn_i, .address_i, .read_i,
    .write_i, .writedata_i, .byteenable_i, .readdata_o(readdata),
    .waitrequest_o(waitreq), .count_input_pin_i(count_pin),
    .fs_clk_i(fs_clk), .pwm_out_pin_o(pin), .cascade_interrupt_o(irq));
  ctp_far_side u_ctp_far_side (.clk_sys_i, .start_i(go),
    .pulses_i(npulse), .count_pin_o(count_pin), .fs_clk_o(fs_clk),
    .busy_o(busy));

  // compares and counts
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic fail;
    err_total++;
    $display("Error at %0t: wait ran out", $time);
    close_out;
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, input logic [31:0] e);
    int n;
    @(posedge clk_sys_i);
    address_i   <= a;
    read_i      <= ~w;
    write_i     <= w;
    writedata_i <= {24'h0, d};
    if (!w) exp_q.push_back(e);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) fail();
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 32'h0);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00, e);
  endtask
  // waits for irq (sel 1) or the pin (sel 0) to show v
  task automatic wait_for(input logic sel, input logic v, input int lim,
                          output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while ((sel ? irq : pin) !== v && n < lim);
    if ((sel ? irq : pin) !== v) fail();
  endtask
  // asks the far side for k falling edges
  task automatic pulses(input logic [7:0] k);
    int n;
    npulse <= k;
    go     <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (busy !== 1'b0) fail();
    repeat (4) @(posedge clk_sys_i);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // takes the oldest noted result as each read completes
  always @(posedge clk_sys_i)
    if (read_i && waitreq === 1'b0 && exp_q.size() > 0)
      check(readdata, exp_q.pop_front());

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    resetn_i = 1'b0;
    read_i = 1'b0;
    write_i = 1'b0;
    go = 1'b0;
    npulse = 8'h00;
    address_i = 5'h00;
    writedata_i = 32'h0;
    byteenable_i = 4'h1;
    rnd = lfsr(8'h38);
    lc = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
           8'h06, 8'h06, 8'h10};
    cm = '{16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1, 16'h1,
           16'h0100, {8'h00, rnd}, 16'h1};
    per = '{4096, 256, 64, 16, 80, 4, 2, 640, 257, rnd + 1, 640};
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(`CTP_OFS_STATUS, 32'h0);
    rd(`CTP_OFS_UPPER_CTRL, 32'h0);
    rd(5'h01, 32'h0);
    byteenable_i <= 4'h0;
    wr(`CTP_OFS_CMP_LO, 8'h55);
    byteenable_i <= 4'h1;
    rd(`CTP_OFS_CMP_LO, 32'h0);
    // interval per source clock, compare written low byte first
    for (i = 0; i < 11; i++) begin
      wr(`CTP_OFS_LOWER_CTRL, lc[i]);
      wr(`CTP_OFS_CMP_LO, cm[i][7:0]);
      wr(`CTP_OFS_CMP_HI, cm[i][15:8]);
      wr(`CTP_OFS_UPPER_CTRL, 8'h04);
      wait_for(1'b1, 1'b1, 9000, g);
      wait_for(1'b1, 1'b1, 9000, g);
      check(g, per[i]);
      wr(`CTP_OFS_UPPER_CTRL, 8'h00);
    end
    // event count, halt and restart
    wr(`CTP_OFS_LOWER_CTRL, 8'h07);
    wr(`CTP_OFS_CMP_LO, 8'h05);
    wr(`CTP_OFS_CMP_HI, 8'h00);
    wr(`CTP_OFS_UPPER_CTRL, 8'h05);
    pulses(8'h03);
    rd(`CTP_OFS_COUNT, 32'h3);
    pulses(8'h04);
    rd(`CTP_OFS_COUNT, 32'h1);
    wr(`CTP_OFS_UPPER_CTRL, 8'h01);
    pulses(8'h02);
    rd(`CTP_OFS_COUNT, 32'h1);
    wr(`CTP_OFS_UPPER_CTRL, 8'h05);
    rd(`CTP_OFS_COUNT, 32'h0);
    wr(`CTP_OFS_UPPER_CTRL, 8'h01);
    // pwm: width 4 loaded while stopped, 16 queued while running
    wr(`CTP_OFS_LOWER_CTRL, 8'h06);
    // reserved mode holds the counter even with fc selected
    wr(`CTP_OFS_UPPER_CTRL, 8'h07);
    repeat (20) @(posedge clk_sys_i);
    rd(`CTP_OFS_COUNT, 32'h0);
    wr(`CTP_OFS_UPPER_CTRL, 8'h03);
    wr(`CTP_OFS_WID_LO, 8'h04);
    wr(`CTP_OFS_WID_HI, 8'h00);
    wr(`CTP_OFS_UPPER_CTRL, 8'h02);
    rd(`CTP_OFS_STATUS, 32'h0);
    wr(`CTP_OFS_UPPER_CTRL, 8'h06);
    wait_for(1'b0, 1'b0, 12, g);
    check(pin, 1'b0);
    wr(`CTP_OFS_WID_LO, 8'h10);
    wr(`CTP_OFS_WID_HI, 8'h00);
    rd(`CTP_OFS_WID_LO, 32'h04);
    check(pin, 1'b0);
    wait_for(1'b0, 1'b1, 70000, g);
    check(irq, 1'b1);
    wait_for(1'b0, 1'b0, 40, g);
    check({31'h0, g > 10}, 32'h1);
    rd(`CTP_OFS_WID_LO, 32'h10);
    // stop holds the pin, then presets set either level
    wr(`CTP_OFS_UPPER_CTRL, 8'h02);
    repeat (20) @(posedge clk_sys_i);
    check(pin, 1'b0);
    rd(`CTP_OFS_STATUS, 32'h1);
    wr(`CTP_OFS_UPPER_CTRL, 8'h02);
    repeat (2) @(posedge clk_sys_i);
    check(pin, 1'b1);
    wr(`CTP_OFS_UPPER_CTRL, 8'h0a);
    repeat (2) @(posedge clk_sys_i);
    check(pin, 1'b0);
    close_out;
  end
endmodule

bind ctp_timer ctp_monitor u_ctp_monitor (.clk_sys_i, .resetn_i,
  .address_i, .read_i, .write_i, .readdata_o, .waitrequest_o,
  .pwm_out_pin_o, .cascade_interrupt_o);
